/* verilog/wdt_consts.vh */
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// Byte addresses on the register bus
`define WDT_ADDR_CTRL_WR     8'h00
`define WDT_ADDR_CTRL_RD     8'h00
`define WDT_ADDR_COUNT_RD    8'h04
`define WDT_ADDR_RSTCTL      8'h08
`define WDT_ADDR_IRQ_STATUS  8'h0C
`define WDT_ADDR_IRQ_MASK    8'h10

// Key in data bits 15:8 that selects the write target
`define WDT_KEY_COUNT        8'h5A
`define WDT_KEY_CTRL         8'hA5
`define WDT_KEY_RST_FIELD    8'h5A
`define WDT_KEY_RST_FLAG     8'hA5

// Control/status field positions
`define WDT_BIT_FLAG         7
`define WDT_BIT_MODE         6
`define WDT_BIT_ENABLE       5
`define WDT_CTRL_FIXED_ONES  8'h18
`define WDT_CTRL_RESET       8'h18

// Reset control/status field positions
`define WDT_BIT_WD_FLAG      7
`define WDT_BIT_RST_EN       6
`define WDT_BIT_SPARE        5
`define WDT_RST_FIXED_ONES   8'h1F
`define WDT_RST_RESET        8'h1F

// Interrupt status bit positions
`define WDT_IRQ_INTERVAL     0
`define WDT_IRQ_WATCHDOG     1

// Prescaler shift per clock select code
`define WDT_SHIFT_0          5'h01
`define WDT_SHIFT_1          5'h06
`define WDT_SHIFT_2          5'h07
`define WDT_SHIFT_3          5'h09
`define WDT_SHIFT_4          5'h0B
`define WDT_SHIFT_5          5'h0D
`define WDT_SHIFT_6          5'h0F
`define WDT_SHIFT_7          5'h11

// Output pulse lengths in peripheral clock cycles
`define WDT_PIN_CYC_RST      10'h085
`define WDT_PIN_CYC_NORST    10'h082
`define WDT_RST_CYC          10'h207

// Bus responses
`define WDT_RESP_OKAY        2'h0
`define WDT_RESP_SLVERR      2'h2

`endif

/* verilog/wdt_prescaler.v */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"

module wdt_prescaler #(
    parameter WIDTH = 17
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire [2:0] sel,
    output reg        tick_ff
);
    reg  [WIDTH-1:0] div_ff;
    reg  [4:0]       shift;
    wire [WIDTH:0]   full_mask;
    wire [WIDTH-1:0] mask;

    // Division select
    always @* begin
        case (sel)
            3'h0: shift = `WDT_SHIFT_0;
            3'h1: shift = `WDT_SHIFT_1;
            3'h2: shift = `WDT_SHIFT_2;
            3'h3: shift = `WDT_SHIFT_3;
            3'h4: shift = `WDT_SHIFT_4;
            3'h5: shift = `WDT_SHIFT_5;
            3'h6: shift = `WDT_SHIFT_6;
            default: shift = `WDT_SHIFT_7;
        endcase
    end

    assign full_mask = ({{WIDTH{1'b0}}, 1'b1} << shift) - {{WIDTH{1'b0}}, 1'b1};
    assign mask      = full_mask[WIDTH-1:0];

    // Held at zero while stopped, so the first tick is a full period
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            div_ff  <= {WIDTH{1'b0}};
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= div_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            tick_ff <= ((div_ff & mask) == mask);
        end
    end
endmodule // wdt_prescaler

`default_nettype wire

/* verilog/wdt_pulse.v */
`timescale 1ns/1ps
`default_nettype none

module wdt_pulse #(
    parameter W = 10
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         start,
    input  wire [W-1:0] len,
    output reg          active_ff
);
    reg [W-1:0] cnt_ff;

    // High for exactly len cycles after start
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff    <= {W{1'b0}};
            active_ff <= 1'b0;
        end else if (start) begin
            cnt_ff    <= len - {{(W-1){1'b0}}, 1'b1};
            active_ff <= 1'b1;
        end else if (cnt_ff != {W{1'b0}}) begin
            cnt_ff    <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        end else begin
            active_ff <= 1'b0;
        end
    end
endmodule // wdt_pulse

`default_nettype wire

/* verilog/watchdog_interval_timer.v */
// Contract
// - Counter is 8-bit readable writable up-counter
// - Enable starts counting; clearing stops, zeroes counter
// - Mode bit: 0 interval, 1 watchdog
// - Interval rollover sets flag, requests interrupt
// - Watchdog overflow drives low output, no interval flag
// - Watchdog overflow may also reset whole chip
// - Flag clears by read-at-1 then write 0
// - Internal reset clears the interval flag
// - Select picks tick from eight clock divisions
// - Control bits 4 and 3 read one
// - Writes need protected keyed access method, except the interrupt mask write
// - Shared write address, word write, low byte
// - Output 133 or 130 cycles, reset 519
// - Reset-enable picks chip reset or timer-only
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"

module watchdog_interval_timer #(
    parameter PRESCALE_W = 17,
    parameter PULSE_W    = 10
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         overflow_out_n,
    output reg         internal_reset,
    output reg         interval_irq,
    output reg         irq
);
    // Timer state
    reg  [7:0]  watchdog_counter_ff;
    reg         interval_overflow_flag_ff;
    reg         watchdog_mode_select_ff;
    reg         count_enable_bit_ff;
    reg  [2:0]  clk_sel_ff;
    reg         wd_flag_ff;
    reg         reset_on_overflow_enable_ff;
    reg         spare_ff;
    reg         flag_armed_ff;
    reg         wd_armed_ff;
    reg  [1:0]  irq_status_ff;
    reg  [1:0]  irq_mask_ff;

    // Bus capture
    reg  [7:0]  aw_addr_ff;
    reg         aw_held_ff;
    reg  [31:0] w_data_ff;
    reg  [3:0]  w_strb_ff;
    reg         w_held_ff;

    wire        tick;
    wire        pin_pulse;
    wire        rst_pulse;
    wire [7:0]  ctrl_rd;
    wire [7:0]  rst_rd;
    wire        wr_go;
    wire        word_ok;
    wire [7:0]  wkey;
    wire [7:0]  wbyte;
    wire        wr_count;
    wire        wr_ctrl;
    wire        wr_rst_field;
    wire        wr_rst_flag;
    wire        rd_go;
    wire        rd_ctrl;
    wire        rd_rst;
    wire        rd_irq;
    wire        overflow;
    wire        iv_event;
    wire        wd_event;
    wire        timer_clear;
    reg  [31:0] rd_word;
    reg         rd_hit;

    assign ctrl_rd = {interval_overflow_flag_ff, watchdog_mode_select_ff,
                      count_enable_bit_ff, 2'b00, clk_sel_ff} | `WDT_CTRL_FIXED_ONES;
    assign rst_rd  = {wd_flag_ff, reset_on_overflow_enable_ff, spare_ff, 5'h00} | `WDT_RST_FIXED_ONES;

    // Write decode: both address and data held, response slot free
    assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign word_ok = (w_strb_ff[1:0] == 2'b11);
    assign wkey    = w_data_ff[15:8];
    assign wbyte   = w_data_ff[7:0];
    assign wr_count     = wr_go && word_ok && aw_addr_ff == `WDT_ADDR_CTRL_WR && wkey == `WDT_KEY_COUNT;
    assign wr_ctrl      = wr_go && word_ok && aw_addr_ff == `WDT_ADDR_CTRL_WR && wkey == `WDT_KEY_CTRL;
    assign wr_rst_field = wr_go && word_ok && aw_addr_ff == `WDT_ADDR_RSTCTL && wkey == `WDT_KEY_RST_FIELD;
    assign wr_rst_flag  = wr_go && word_ok && aw_addr_ff == `WDT_ADDR_RSTCTL && wkey == `WDT_KEY_RST_FLAG;

    // Read decode, one read in flight
    assign rd_go   = s_axi_arvalid && s_axi_arready;
    assign rd_ctrl = rd_go && s_axi_araddr == `WDT_ADDR_CTRL_RD;
    assign rd_rst  = rd_go && s_axi_araddr == `WDT_ADDR_RSTCTL;
    assign rd_irq  = rd_go && s_axi_araddr == `WDT_ADDR_IRQ_STATUS;

    // count on tick
    // A counter write in the same cycle wins, so a refresh never overflows
    assign overflow = tick && count_enable_bit_ff && !wr_count && watchdog_counter_ff == 8'hFF;
    assign iv_event = overflow && !watchdog_mode_select_ff;
    assign wd_event = overflow && watchdog_mode_select_ff;
    // timer always reset
    // Counter and control reset on every watchdog overflow and during the chip reset
    assign timer_clear = wd_event || rst_pulse;

    wdt_prescaler #(
        .WIDTH (PRESCALE_W)
    ) u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (count_enable_bit_ff),
        .sel     (clk_sel_ff),
        .tick_ff (tick)
    );

    wdt_pulse #(
        .W (PULSE_W)
    ) u_pin_pulse (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (wd_event),
        .len       (reset_on_overflow_enable_ff ? `WDT_PIN_CYC_RST : `WDT_PIN_CYC_NORST),
        .active_ff (pin_pulse)
    );

    wdt_pulse #(
        .W (PULSE_W)
    ) u_rst_pulse (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (wd_event && reset_on_overflow_enable_ff),
        .len       (`WDT_RST_CYC),
        .active_ff (rst_pulse)
    );

    // Counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_counter_ff <= 8'h00;
        end else if (timer_clear || !count_enable_bit_ff) begin
            watchdog_counter_ff <= 8'h00;
        end else if (wr_count) begin
            watchdog_counter_ff <= wbyte;
        end else if (tick) begin
            watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
        end
    end

    // Control/status fields
    always @(posedge aclk) begin
        if (!aresetn || timer_clear) begin
            watchdog_mode_select_ff <= 1'b0;
            count_enable_bit_ff     <= 1'b0;
            clk_sel_ff              <= 3'h0;
        end else if (wr_ctrl) begin
            watchdog_mode_select_ff <= wbyte[`WDT_BIT_MODE];
            count_enable_bit_ff     <= wbyte[`WDT_BIT_ENABLE];
            clk_sel_ff              <= wbyte[2:0];
        end
    end

    // Interval flag; a new overflow wins over a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            interval_overflow_flag_ff <= 1'b0;
            flag_armed_ff             <= 1'b0;
        end else if (timer_clear) begin
            interval_overflow_flag_ff <= 1'b0;
            flag_armed_ff             <= 1'b0;
        end else if (iv_event) begin
            interval_overflow_flag_ff <= 1'b1;
        end else if (wr_ctrl && !wbyte[`WDT_BIT_FLAG] && flag_armed_ff) begin
            interval_overflow_flag_ff <= 1'b0;
            flag_armed_ff             <= 1'b0;
        end else if (rd_ctrl && interval_overflow_flag_ff) begin
            flag_armed_ff <= 1'b1;
        end
    end

    // Reset control register; the chip reset pulse does not touch it
    always @(posedge aclk) begin
        if (!aresetn) begin
            wd_flag_ff                  <= 1'b0;
            wd_armed_ff                 <= 1'b0;
            reset_on_overflow_enable_ff <= 1'b0;
            spare_ff                    <= 1'b0;
        end else begin
            if (wr_rst_field) begin
                reset_on_overflow_enable_ff <= wbyte[`WDT_BIT_RST_EN];
                spare_ff                    <= wbyte[`WDT_BIT_SPARE];
            end
            if (wd_event) begin
                wd_flag_ff <= 1'b1;
            end else if (wr_rst_flag && !wbyte[`WDT_BIT_WD_FLAG] && wd_armed_ff) begin
                wd_flag_ff  <= 1'b0;
                wd_armed_ff <= 1'b0;
            end else if (rd_rst && wd_flag_ff) begin
                wd_armed_ff <= 1'b1;
            end
        end
    end

    // Sticky event bits, cleared by reading; an event wins over that read
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_ff <= 2'b00;
            irq_mask_ff   <= 2'b00;
        end else begin
            irq_status_ff[`WDT_IRQ_INTERVAL] <= iv_event ||
                (irq_status_ff[`WDT_IRQ_INTERVAL] && !rd_irq);
            irq_status_ff[`WDT_IRQ_WATCHDOG] <= wd_event ||
                (irq_status_ff[`WDT_IRQ_WATCHDOG] && !rd_irq);
            if (wr_go && aw_addr_ff == `WDT_ADDR_IRQ_MASK && w_strb_ff[0]) begin
                irq_mask_ff <= w_data_ff[1:0];
            end
        end
    end

    // Registered pins
    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_out_n <= 1'b1;
            internal_reset <= 1'b0;
            interval_irq   <= 1'b0;
            irq            <= 1'b0;
        end else begin
            overflow_out_n <= !pin_pulse;
            internal_reset <= rst_pulse;
            interval_irq   <= interval_overflow_flag_ff;
            irq            <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // Write channels taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            aw_addr_ff    <= 8'h00;
            w_data_ff     <= 32'h00000000;
            w_strb_ff     <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_go) begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_ff <= 1'b0;
            end
            s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    // Wrong key or narrow writes to keyed registers are dropped silently with OKAY, as a real guard would
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WDT_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_ff)
                `WDT_ADDR_CTRL_WR, `WDT_ADDR_RSTCTL, `WDT_ADDR_IRQ_STATUS, `WDT_ADDR_IRQ_MASK:
                    s_axi_bresp <= `WDT_RESP_OKAY;
                default:
                    s_axi_bresp <= `WDT_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `WDT_ADDR_CTRL_RD:    rd_word = {24'h000000, ctrl_rd};
            `WDT_ADDR_COUNT_RD:   rd_word = {24'h000000, watchdog_counter_ff};
            `WDT_ADDR_RSTCTL:     rd_word = {24'h000000, rst_rd};
            `WDT_ADDR_IRQ_STATUS: rd_word = {30'h00000000, irq_status_ff};
            `WDT_ADDR_IRQ_MASK:   rd_word = {30'h00000000, irq_mask_ff};
            default:              rd_hit  = 1'b0;
        endcase
    end

    // Read channel: answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `WDT_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // watchdog_interval_timer

`default_nettype wire

/* tb/wdt_pin_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_pin_monitor (
    input  wire logic aclk,
    input  wire logic clr,
    input  wire logic overflow_out_n,
    input  wire logic internal_reset,
    input  wire logic interval_irq,
    output var  int   low_len,
    output var  int   rst_len,
    output var  logic irq_seen
);
    int lo_n = 0;
    int hi_n = 0;
    // Widths latched as each pulse ends; the system side only listens
    always @(posedge aclk) begin
        lo_n <= overflow_out_n ? 0 : lo_n + 1;
        hi_n <= internal_reset ? hi_n + 1 : 0;
        if (clr) begin
            low_len  <= 0;
            rst_len  <= 0;
            irq_seen <= 1'b0;
        end else begin
            if (overflow_out_n && lo_n != 0) low_len <= lo_n;
            if (!internal_reset && hi_n != 0) rst_len <= hi_n;
            if (interval_irq && !overflow_out_n) irq_seen <= 1'b1;
        end
    end
endmodule // wdt_pin_monitor
`default_nettype wire

/* tb/wdt_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        overflow_out_n,
    input wire logic        internal_reset,
    input wire logic        interval_irq
);
    logic [9:0] low_ff;
    logic [9:0] high_ff;
    logic       rst_in_low_ff;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pulse widths; a 10-bit count covers the longest pulse
    always @(posedge aclk) begin
        if (!aresetn) begin
            low_ff        <= 10'h000;
            high_ff       <= 10'h000;
            rst_in_low_ff <= 1'b0;
        end else begin
            low_ff        <= overflow_out_n ? 10'h000 : low_ff + 10'h001;
            high_ff       <= internal_reset ? high_ff + 10'h001 : 10'h000;
            rst_in_low_ff <= !overflow_out_n && (rst_in_low_ff || internal_reset);
        end
    end
    a_pin_len: assert property ($rose(overflow_out_n) |-> low_ff == (rst_in_low_ff ? 10'h085 : 10'h082))
        else $error("overflow pulse width wrong");
    a_rst_len: assert property ($fell(internal_reset) |-> high_ff == 10'h207)
        else $error("chip reset pulse width wrong");
    a_rst_with_ovf: assert property ($rose(internal_reset) |-> ##[0:2] !overflow_out_n)
        else $error("chip reset without overflow output");
    a_wd_no_flag: assert property (!overflow_out_n |-> !$rose(interval_irq))
        else $error("flag raised by watchdog overflow");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    c_chip_reset: cover property ($rose(internal_reset));
    c_interval: cover property ($rose(interval_irq));
    c_rd_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // wdt_checker
bind watchdog_interval_timer wdt_checker i_wdt_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .overflow_out_n(overflow_out_n),
    .internal_reset(internal_reset), .interval_irq(interval_irq)
);
`default_nettype wire

/* tb/watchdog_interval_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        clr = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        overflow_out_n, internal_reset, interval_irq, irq, irq_seen;
    int          low_len, rst_len;
    int          mismatches = 0;
    int          checked = 0;
    int          cyc = 0;
    int          exp_q[$] = {133, 519, 130, 0};

    watchdog_interval_timer i_watchdog_interval_timer (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .overflow_out_n(overflow_out_n),
        .internal_reset(internal_reset), .interval_irq(interval_irq), .irq(irq)
    );
    wdt_pin_monitor i_wdt_pin_monitor (
        .aclk(aclk), .clr(clr), .overflow_out_n(overflow_out_n), .internal_reset(internal_reset),
        .interval_irq(interval_irq), .low_len(low_len), .rst_len(rst_len), .irq_seen(irq_seen)
    );

    always #2.5 aclk = ~aclk;
    // Cycle count doubles as hang guard; updated late so readers see a stable value
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3,
                      input logic [1:0] r = 2'h0);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, r);
        s_axi_bready <= 1'b0;
    endtask

    // Ready raised a cycle late so the slave has to hold its data
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk(s_axi_rresp, r);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    task automatic wait_flag();
        int n;
        n = 0;
        while (!interval_irq && n < 40000) begin
            @(posedge aclk);
            n++;
        end
    endtask

    initial begin
        logic [31:0] d;
        logic [2:0]  s3;
        int          t1, dv, e_low, e_rst, n;
        d = $urandom(32'hD784);
        do_reset();
        rdc(8'h00, 32'h18);
        rdc(8'h04, 32'h00);
        rdc(8'h08, 32'h1F);
        // Unkeyed and narrow writes leave control alone
        wr(8'h00, 16'h0027, 4'hF);
        wr(8'h00, 16'hA527, 4'h1);
        rdc(8'h00, 32'h18);
        // Flag and fixed bits ignore writes; unmapped place errors
        s3 = 3'($urandom % 8);
        wr(8'h00, {8'hA5, 5'h10, s3});
        wr(8'h14, 16'hA520, 4'h3, 2'h2);
        rd(8'h14, d, 2'h2);
        rdc(8'h00, {27'h3, s3});
        // Slowest division: no tick can disturb the written count
        wr(8'h00, 16'hA527);
        d = $urandom;
        wr(8'h00, {8'h5A, d[7:0]});
        rdc(8'h04, {24'h0, d[7:0]});
        wr(8'h00, 16'hA507);
        rdc(8'h04, 32'h00);
        // Interval periods, flag clear protocol, masked and unmasked irq
        for (int c = 0; c < 2; c++) begin
            dv = c ? 64 : 2;
            do_reset();
            wr(8'h10, {15'h0, c == 0});
            wr(8'h00, {8'hA5, 5'h04, c[2:0]});
            wr(8'h00, 16'h5AFF);
            wait_flag();
            t1 = cyc;
            wr(8'h00, {8'hA5, 5'h04, c[2:0]});
            chk(interval_irq, 1'b1);
            chk(irq, c == 0);
            wr(8'h00, {8'hA5, 5'h14, c[2:0]});
            chk(interval_irq, 1'b1);
            rdc(8'h00, {24'h0, 5'h17, c[2:0]});
            wr(8'h00, {8'hA5, 5'h04, c[2:0]});
            rdc(8'h00, {24'h0, 5'h07, c[2:0]});
            chk(interval_irq, 1'b0);
            rdc(8'h0C, 32'h1);
            rdc(8'h0C, 32'h0);
            chk(irq, 1'b0);
            wait_flag();
            chk(cyc - t1, 256 * dv);
        end
        // Watchdog overflow with and without chip reset; watchdog flag set, then cleared
        for (int e = 1; e >= 0; e--) begin
            e_low = exp_q.pop_front();
            e_rst = exp_q.pop_front();
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            wr(8'h08, {8'h5A, 1'b0, e[0], 6'h00});
            wr(8'h00, 16'hA560);
            wr(8'h00, 16'h5AFE);
            n = 0;
            while ((low_len == 0 || rst_len != e_rst) && n < 3000) begin
                @(posedge aclk);
                n++;
            end
            chk(low_len, e_low);
            chk(rst_len, e_rst);
            chk(irq_seen, 1'b0);
            rdc(8'h00, 32'h18);
            rdc(8'h08, {24'h0, 1'b1, e[0], 6'h1F});
            rdc(8'h0C, e ? 32'h3 : 32'h2);
            wr(8'h08, 16'hA500);
            rdc(8'h08, {24'h0, 1'b0, e[0], 6'h1F});
        end
        end_sim();
    end
endmodule // watchdog_interval_timer_tb
`default_nettype wire
